/* hdl/tpw_pkg.sv */
// Purpose: shared constants for the triple 11-bit pwm block
// Assumes: byte-wide register port, 25 MHz system clock
// Notes:   offsets are register indices on the plain port
package tpw_pkg;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 4;
  localparam int          BOUND_W      = 10;   // counter bound width
  localparam int          DUTY_W       = 11;   // duty bound incl. half step
  localparam int          NCHAN        = 3;
  // register offsets
  localparam logic [3:0]  OFS_DUTY_HI0 = 4'h0;
  localparam logic [3:0]  OFS_DUTY_LO0 = 4'h1;
  localparam logic [3:0]  OFS_DUTY_HI1 = 4'h2;
  localparam logic [3:0]  OFS_DUTY_LO1 = 4'h3;
  localparam logic [3:0]  OFS_DUTY_HI2 = 4'h4;
  localparam logic [3:0]  OFS_DUTY_LO2 = 4'h5;
  localparam logic [3:0]  OFS_BOUND_HI = 4'h6;
  localparam logic [3:0]  OFS_BOUND_LO = 4'h7;
  localparam logic [3:0]  OFS_CLK_CTRL = 4'h8;
  localparam logic [3:0]  OFS_OUT_CTL0 = 4'h9;
  localparam logic [3:0]  OFS_OUT_CTL1 = 4'ha;
  localparam logic [3:0]  OFS_OUT_CTL2 = 4'hb;
  localparam logic [3:0]  OFS_STATUS   = 4'hc;
  // clock control fields
  localparam int          CLK_EN_BIT   = 7;
  localparam int          PRE_LSB      = 4;    // prescale field [6:4]
  localparam int          SRC_BIT      = 0;    // 1 = internal fast osc
  // output control fields
  localparam int          OC_EN_BIT    = 7;
  localparam int          OC_INV_BIT   = 6;
  localparam int          OC_XOR_BIT   = 5;    // chan0 only: xor with chan1
  localparam int          OC_OR_BIT    = 4;    // chan0 only: or with chan1
  localparam int          OC_PIN_LSB   = 0;    // pin select [1:0]
  // pin vector positions
  localparam int          PIN_PA0 = 0;
  localparam int          PIN_PA3 = 1;
  localparam int          PIN_PA4 = 2;
  localparam int          PIN_PA5 = 3;
  localparam int          PIN_PB2 = 4;
  localparam int          PIN_PB3 = 5;
  localparam int          PIN_PB4 = 6;
  localparam int          PIN_PB5 = 7;
  localparam int          PIN_PB6 = 8;
  localparam int          PIN_PB7 = 9;
  localparam int          NPIN    = 10;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [7:0]  UNMAPPED = 8'h00;
endpackage : tpw_pkg

/* hdl/tpw_tick_if.sv */
// Purpose: carries the shared count tick and period state between modules
// Assumes: single clock domain
// Notes:   driven by the time base, read by the channel comparators
`timescale 1ns/1ps
interface tpw_tick_if;
  logic                           tick;        // one-cycle count enable
  logic                           wrap;        // tick that starts a new period
  logic [tpw_pkg::BOUND_W-1:0]    count;       // shared up-counter
  modport base (output tick, output wrap, output count);
  modport chan (input tick, input wrap, input count);
endinterface : tpw_tick_if

/* hdl/tpw_base.sv */
// Purpose: shared prescaler and up-counter for all three channels
// Assumes: fast oscillator arrives as an already synchronised enable
// Notes:   bound is shadowed and taken at wrap or while stopped
`timescale 1ns/1ps
module tpw_base (
  input  wire logic                        clock_i,
  input  wire logic                        nrst_i,
  input  wire logic                        run_i,     // enabled and source running: not halted, or osc on
  input  wire logic                        src_i,     // 1 = fast oscillator
  input  wire logic                        osc_en_i,  // fast oscillator pulse
  input  wire logic [2:0]                  pre_i,     // divide by 2**pre
  input  wire logic [tpw_pkg::BOUND_W-1:0] bound_i,   // shadowed bound
  tpw_tick_if.base                         tb
);
  logic [6:0] pre_reg;                                // prescale counter
  logic       src_tick;
  logic       pre_hit;
  logic [6:0] pre_mask;

  // system clock ticks every cycle, oscillator on its own pulses
  assign src_tick = src_i ? osc_en_i : 1'b1;
  assign pre_mask = 7'((8'h01 << pre_i) - 8'h01);
  assign pre_hit  = (pre_reg & pre_mask) == pre_mask;

  // prescaler counts selected source pulses
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_reg <= 7'h00;
    end else if (!run_i) begin
      pre_reg <= 7'h00;
    end else if (src_tick) begin
      pre_reg <= pre_hit ? 7'h00 : pre_reg + 7'h01;
    end
  end

  assign tb.tick = run_i && src_tick && pre_hit;
  assign tb.wrap = tb.tick && (tb.count >= bound_i);

  // shared up-counter, one for all three channels so edges line up
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tb.count <= '0;
    end else if (tb.wrap) begin
      tb.count <= '0;
    end else if (tb.tick) begin
      tb.count <= tb.count + 1'b1;
    end
  end
endmodule : tpw_base

/* hdl/tpw_chan.sv */
// Purpose: one duty comparator with half-step resolution
// Assumes: counter ticks at prescaled rate; system clock is faster
// Notes:   half step realised by holding high for half a tick period
`timescale 1ns/1ps
module tpw_chan (
  input  wire logic                        clock_i,
  input  wire logic                        nrst_i,
  input  wire logic [tpw_pkg::DUTY_W-1:0]  duty_i,    // shadowed duty bound
  input  wire logic                        half_ph_i, // second half of tick
  tpw_tick_if.chan                         tb,
  output logic                             pwm_o
);
  logic [tpw_pkg::BOUND_W-1:0] upper;
  logic                        hs;
  assign upper = duty_i[tpw_pkg::DUTY_W-1:1];
  assign hs    = duty_i[0];

  // high from period start for upper+hs/2+1/2 count steps
  always_comb begin
    if (tb.count < upper) begin
      pwm_o = 1'b1;
    end else if (tb.count == upper) begin
      // half step fills the second half of the last tick, no further tick
      pwm_o = hs ? 1'b1 : !half_ph_i;
    end else begin
      pwm_o = 1'b0;
    end
  end
endmodule : tpw_chan

/* hdl/tpw_top.sv */
// Purpose: three 11-bit pwm generators on one shared time base
// Assumes: byte register port, read data one cycle after read strobe
// Notes:   bound and duty values are shadowed into the next period
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module tpw_top #(
  parameter bit GATE_OPT = 1'b0                       // comparator gating build option
) (
  input  wire logic                       clock_i,
  input  wire logic                       nrst_i,
  input  wire logic [tpw_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [tpw_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [tpw_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                       osc_i,      // fast oscillator level
  input  wire logic                       osc_on_i,   // fast oscillator running
  input  wire logic                       halt_i,     // cpu halted power save
  input  wire logic                       cmp_i,      // comparator result
  output logic      [tpw_pkg::NPIN-1:0]   pin_o,      // pin drive values
  output logic      [tpw_pkg::NPIN-1:0]   pin_oe_o    // pin drive enables
);
  localparam int NC = tpw_pkg::NCHAN;

  // software registers
  logic [7:0] duty_hi_reg [NC];
  logic [7:0] duty_lo_reg [NC];
  logic [7:0] out_ctl_reg [NC];
  logic [7:0] bound_hi_reg;
  logic [7:0] bound_lo_reg;
  logic [7:0] clk_ctl_reg;
  // shadow copies live for the running period
  logic [tpw_pkg::DUTY_W-1:0]  duty_sh_reg [NC];
  logic [tpw_pkg::BOUND_W-1:0] bound_sh_reg;
  // oscillator and comparator synchronisers
  logic [2:0] osc_sync_reg;
  logic [2:0] osc_on_sync_reg;
  logic [2:0] cmp_sync_reg;
  logic       osc_lvl_reg;
  logic       osc_on_reg;
  logic       cmp_reg;
  logic       osc_pulse;
  logic       half_ph_reg;                            // second half of a tick
  logic [7:0] tick_half_cnt_reg;                      // cycles inside a tick
  logic [7:0] tick_len_reg;                           // last tick length
  logic       run;
  logic [NC-1:0] raw;
  logic [NC-1:0] chan_out;
  logic [tpw_pkg::NPIN-1:0] pin_next;
  logic [tpw_pkg::NPIN-1:0] oe_next;
  logic [7:0] rdata_next;

  tpw_tick_if tb ();

  // three-stage sync, change counted once last two agree
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_sync_reg    <= 3'h0;
      osc_on_sync_reg <= 3'h0;
      cmp_sync_reg    <= 3'h0;
      osc_lvl_reg     <= 1'b0;
      osc_on_reg      <= 1'b0;
      cmp_reg         <= 1'b0;
    end else begin
      osc_sync_reg    <= {osc_sync_reg[1:0], osc_i};
      osc_on_sync_reg <= {osc_on_sync_reg[1:0], osc_on_i};
      cmp_sync_reg    <= {cmp_sync_reg[1:0], cmp_i};
      if (osc_sync_reg[1] == osc_sync_reg[2]) begin
        osc_lvl_reg <= osc_sync_reg[2];
      end
      if (osc_on_sync_reg[1] == osc_on_sync_reg[2]) begin
        osc_on_reg <= osc_on_sync_reg[2];
      end
      if (cmp_sync_reg[1] == cmp_sync_reg[2]) begin
        cmp_reg <= cmp_sync_reg[2];
      end
    end
  end

  // rising edge of the settled oscillator level
  assign osc_pulse = (osc_sync_reg[1] == osc_sync_reg[2]) && osc_sync_reg[2] && !osc_lvl_reg;

  // halted: system clock source stops; oscillator source needs osc on
  assign run = clk_ctl_reg[tpw_pkg::CLK_EN_BIT] &&
               (clk_ctl_reg[tpw_pkg::SRC_BIT] ? osc_on_reg : !halt_i);

  tpw_base u_base (
    .clock_i  (clock_i),
    .nrst_i   (nrst_i),
    .run_i    (run),
    .src_i    (clk_ctl_reg[tpw_pkg::SRC_BIT]),
    .osc_en_i (osc_pulse),
    .pre_i    (clk_ctl_reg[tpw_pkg::PRE_LSB +: 3]),
    .bound_i  (bound_sh_reg),
    .tb       (tb.base)
  );

  // measure tick length so the half step lands mid-tick
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_half_cnt_reg <= 8'h00;
      tick_len_reg      <= 8'h00;
      half_ph_reg       <= 1'b0;
    end else if (tb.tick) begin
      tick_half_cnt_reg <= 8'h00;
      tick_len_reg      <= tick_half_cnt_reg;
      half_ph_reg       <= 1'b0;
    end else begin
      if (tick_half_cnt_reg != 8'hff) begin
        tick_half_cnt_reg <= tick_half_cnt_reg + 8'h01;
      end
      if (tick_half_cnt_reg >= {1'b0, tick_len_reg[7:1]}) begin
        half_ph_reg <= 1'b1;
      end
    end
  end

  // shadow load at period start keeps pulses whole
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bound_sh_reg <= '0;
    end else if (tb.wrap || !run) begin
      bound_sh_reg <= {bound_hi_reg, bound_lo_reg[7:6]};
    end
  end

  // per channel duty shadow and comparator
  for (genvar c = 0; c < NC; c++) begin : g_chan
    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        duty_sh_reg[c] <= '0;
      end else if (tb.wrap || !run) begin
        duty_sh_reg[c] <= {duty_hi_reg[c], duty_lo_reg[c][7:5]};
      end
    end
    tpw_chan u_chan (
      .clock_i   (clock_i),
      .nrst_i    (nrst_i),
      .duty_i    (duty_sh_reg[c]),
      .half_ph_i (half_ph_reg),
      .tb        (tb.chan),
      .pwm_o     (raw[c])
    );
  end

  // combining and inversion; chan0 may mix in chan1
  always_comb begin
    logic c0;
    c0 = raw[0];
    if (out_ctl_reg[0][tpw_pkg::OC_XOR_BIT]) begin
      c0 = raw[0] ^ raw[1];
    end else if (out_ctl_reg[0][tpw_pkg::OC_OR_BIT]) begin
      c0 = raw[0] | raw[1];
    end
    chan_out[0] = c0 ^ out_ctl_reg[0][tpw_pkg::OC_INV_BIT];
    chan_out[1] = raw[1] ^ out_ctl_reg[1][tpw_pkg::OC_INV_BIT];
    chan_out[2] = raw[2] ^ out_ctl_reg[2][tpw_pkg::OC_INV_BIT];
    if (GATE_OPT && cmp_reg) begin
      chan_out = '0;
    end
    // no hold logic while stopped: the frozen counter and the saturated
    // half-tick phase keep every level steady once that phase has set
  end

  // pin routing; each channel has its own allowed pin list
  always_comb begin
    logic [1:0] s0;
    logic [1:0] s1;
    logic [1:0] s2;
    s0 = out_ctl_reg[0][tpw_pkg::OC_PIN_LSB +: 2];
    s1 = out_ctl_reg[1][tpw_pkg::OC_PIN_LSB +: 2];
    s2 = out_ctl_reg[2][tpw_pkg::OC_PIN_LSB +: 2];
    pin_next = '0;
    oe_next  = '0;
    if (out_ctl_reg[0][tpw_pkg::OC_EN_BIT]) begin
      unique case (s0)
        2'h0:    begin oe_next[tpw_pkg::PIN_PA0] = 1'b1; pin_next[tpw_pkg::PIN_PA0] = chan_out[0]; end
        2'h1:    begin oe_next[tpw_pkg::PIN_PB4] = 1'b1; pin_next[tpw_pkg::PIN_PB4] = chan_out[0]; end
        2'h2:    begin oe_next[tpw_pkg::PIN_PB5] = 1'b1; pin_next[tpw_pkg::PIN_PB5] = chan_out[0]; end
        default: ;                                    // no pin
      endcase
    end
    if (out_ctl_reg[1][tpw_pkg::OC_EN_BIT]) begin
      unique case (s1)
        2'h0:    begin oe_next[tpw_pkg::PIN_PA4] = 1'b1; pin_next[tpw_pkg::PIN_PA4] = chan_out[1]; end
        2'h1:    begin oe_next[tpw_pkg::PIN_PB6] = 1'b1; pin_next[tpw_pkg::PIN_PB6] = chan_out[1]; end
        2'h2:    begin oe_next[tpw_pkg::PIN_PB7] = 1'b1; pin_next[tpw_pkg::PIN_PB7] = chan_out[1]; end
        default: ;                                    // no pin
      endcase
    end
    if (out_ctl_reg[2][tpw_pkg::OC_EN_BIT]) begin
      unique case (s2)
        2'h0: begin oe_next[tpw_pkg::PIN_PA3] = 1'b1; pin_next[tpw_pkg::PIN_PA3] = chan_out[2]; end
        2'h1: begin oe_next[tpw_pkg::PIN_PB2] = 1'b1; pin_next[tpw_pkg::PIN_PB2] = chan_out[2]; end
        2'h2: begin oe_next[tpw_pkg::PIN_PB3] = 1'b1; pin_next[tpw_pkg::PIN_PB3] = chan_out[2]; end
        2'h3: begin oe_next[tpw_pkg::PIN_PA5] = 1'b1; pin_next[tpw_pkg::PIN_PA5] = chan_out[2]; end
      endcase
    end
  end

  // pins straight from flops
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_o    <= '0;
      pin_oe_o <= '0;
    end else begin
      pin_o    <= pin_next;
      pin_oe_o <= oe_next;
    end
  end

  // register writes
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NC; i++) begin
        duty_hi_reg[i] <= tpw_pkg::RST_BYTE;
        duty_lo_reg[i] <= tpw_pkg::RST_BYTE;
        out_ctl_reg[i] <= tpw_pkg::RST_BYTE;
      end
      bound_hi_reg <= tpw_pkg::RST_BYTE;
      bound_lo_reg <= tpw_pkg::RST_BYTE;
      clk_ctl_reg  <= tpw_pkg::RST_BYTE;
    end else if (wr_i) begin
      unique case (addr_i)
        tpw_pkg::OFS_DUTY_HI0: duty_hi_reg[0] <= wdata_i;
        tpw_pkg::OFS_DUTY_LO0: duty_lo_reg[0] <= wdata_i & 8'he0;
        tpw_pkg::OFS_DUTY_HI1: duty_hi_reg[1] <= wdata_i;
        tpw_pkg::OFS_DUTY_LO1: duty_lo_reg[1] <= wdata_i & 8'he0;
        tpw_pkg::OFS_DUTY_HI2: duty_hi_reg[2] <= wdata_i;
        tpw_pkg::OFS_DUTY_LO2: duty_lo_reg[2] <= wdata_i & 8'he0;
        tpw_pkg::OFS_BOUND_HI: bound_hi_reg   <= wdata_i;
        tpw_pkg::OFS_BOUND_LO: bound_lo_reg   <= wdata_i & 8'hc0;
        tpw_pkg::OFS_CLK_CTRL: clk_ctl_reg    <= wdata_i & 8'hf1;
        tpw_pkg::OFS_OUT_CTL0: out_ctl_reg[0] <= wdata_i & 8'hf3;
        tpw_pkg::OFS_OUT_CTL1: out_ctl_reg[1] <= wdata_i & 8'hc3;
        tpw_pkg::OFS_OUT_CTL2: out_ctl_reg[2] <= wdata_i & 8'hc3;
        default: ;                                    // unmapped writes dropped
      endcase
    end
  end

  // read mux; status shows run state and top counter bits
  always_comb begin
    unique case (addr_i)
      tpw_pkg::OFS_DUTY_HI0: rdata_next = duty_hi_reg[0];
      tpw_pkg::OFS_DUTY_LO0: rdata_next = duty_lo_reg[0];
      tpw_pkg::OFS_DUTY_HI1: rdata_next = duty_hi_reg[1];
      tpw_pkg::OFS_DUTY_LO1: rdata_next = duty_lo_reg[1];
      tpw_pkg::OFS_DUTY_HI2: rdata_next = duty_hi_reg[2];
      tpw_pkg::OFS_DUTY_LO2: rdata_next = duty_lo_reg[2];
      tpw_pkg::OFS_BOUND_HI: rdata_next = bound_hi_reg;
      tpw_pkg::OFS_BOUND_LO: rdata_next = bound_lo_reg;
      tpw_pkg::OFS_CLK_CTRL: rdata_next = clk_ctl_reg;
      tpw_pkg::OFS_OUT_CTL0: rdata_next = out_ctl_reg[0];
      tpw_pkg::OFS_OUT_CTL1: rdata_next = out_ctl_reg[1];
      tpw_pkg::OFS_OUT_CTL2: rdata_next = out_ctl_reg[2];
      tpw_pkg::OFS_STATUS:   rdata_next = {run, chan_out, 1'b0, tb.count[9:7]};
      default:               rdata_next = tpw_pkg::UNMAPPED;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rdata_next : '0;
    end
  end
endmodule : tpw_top

/* test/tpw_top_asserts.sv */
// Purpose: port-level checks for the triple pwm block
// Assumes: one clock, asynchronous active-low reset
// Notes:   readback checks expect the bench's write, gap, read pattern
`timescale 1ns/1ps
module tpw_top_asserts #(
  parameter bit GATE_OPT = 1'b0            // comparator gating build option
) (
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       osc_i,
  input wire logic       osc_on_i,
  input wire logic       halt_i,
  input wire logic       cmp_i,
  input wire logic [9:0] pin_o,
  input wire logic [9:0] pin_oe_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  // read data is zero outside the answer cycle
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read answer");
  // unmapped places read zero
  AST_UNMAPPED: assert property (rd_i && addr_i > 4'hc |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  // duty high byte keeps all eight bits
  AST_DUTY_RB: assert property ((wr_i && addr_i == 4'h0) ##1 !wr_i ##1
    (rd_i && addr_i == 4'h0) |=> rdata_o == $past(wdata_i, 3))
    else $error("duty high readback wrong");
  // bound high byte keeps all eight bits
  AST_BOUND_RB: assert property ((wr_i && addr_i == 4'h6) ##1 !wr_i ##1
    (rd_i && addr_i == 4'h6) |=> rdata_o == $past(wdata_i, 3))
    else $error("bound high readback wrong");
  // clock control keeps enable, prescale and source only
  AST_CLK_RB: assert property ((wr_i && addr_i == 4'h8) ##1 !wr_i ##1
    (rd_i && addr_i == 4'h8) |=> rdata_o == ($past(wdata_i, 3) & 8'hf1))
    else $error("clock control readback wrong");
  // each channel drives at most one of its pins
  AST_CH0_PINS: assert property ($onehot0({pin_oe_o[0], pin_oe_o[6], pin_oe_o[7]}))
    else $error("channel 0 drives two pins");
  AST_CH1_PINS: assert property ($onehot0({pin_oe_o[2], pin_oe_o[8], pin_oe_o[9]}))
    else $error("channel 1 drives two pins");
  AST_CH2_PINS: assert property (
    $onehot0({pin_oe_o[1], pin_oe_o[3], pin_oe_o[4], pin_oe_o[5]}))
    else $error("channel 2 drives two pins");
  // halted with oscillator off: counter frozen, pins hold once the
  // synchroniser and the half-tick phase have settled (16 cycles)
  AST_HALT_HOLD: assert property ((halt_i && !osc_on_i && !wr_i && !cmp_i)[*8] ##1
    (halt_i && !osc_on_i && !wr_i && !cmp_i)[*8] |-> $stable(pin_o) && $stable(pin_oe_o))
    else $error("pins moved while halted");
endmodule : tpw_top_asserts
bind tpw_top tpw_top_asserts #(.GATE_OPT(GATE_OPT)) u_chk (.clock_i(clock_i),
  .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .osc_i(osc_i), .osc_on_i(osc_on_i), .halt_i(halt_i),
  .cmp_i(cmp_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));

/* test/tpw_load_model.sv */
// Purpose: external loads on the ten pwm pins
// Assumes: every load has a weak pull-down
// Notes:   a released pin reads low, never the last driven value
`timescale 1ns/1ps
module tpw_load_model (
  input  wire logic [9:0] pin_o,     // driven values
  input  wire logic [9:0] pin_oe_o,  // drive enables
  output logic      [9:0] level_o    // level seen on the wire
);
  // released pins fall to the pull-down level
  assign level_o = pin_o & pin_oe_o;
endmodule : tpw_load_model

/* test/triple_pwm_11bit_shared_base_tb_top.sv */
// Purpose: directed bench for the triple pwm block
// Assumes: 25 MHz clock, read data one cycle after the read strobe
// Notes:   bound 17, prescale 1 gives a 36 cycle period
`timescale 1ns/1ps
module triple_pwm_11bit_shared_base_tb_top;
  logic       clock_i;
  logic       nrst_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       osc_i = 1'b0;
  logic       osc_on_i;
  logic       halt_i;
  logic       cmp_i;
  logic [9:0] pin_o;
  logic [9:0] pin_oe_o;
  logic [9:0] level;     // wire level after loads
  logic [2:0] osc_div = 3'h0; // fast oscillator divider
  logic [7:0] rd_val;    // last read answer
  int         error_cnt;
  int         checks;
  int         n;
  int         ch2_pin[4] = '{1, 4, 5, 3};  // pin index per ch2 select code

  tpw_top #(.GATE_OPT(1'b1)) dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_i(osc_i),
    .osc_on_i(osc_on_i), .halt_i(halt_i), .cmp_i(cmp_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
  tpw_load_model u_load (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .level_o(level));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  // fast oscillator at an eighth of the system clock, well inside its limit
  always @(posedge clock_i) begin
    osc_div <= osc_div + 3'h1;
    osc_i   <= osc_div[2];
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task automatic chk_val(input string what, input logic [19:0] exp, input logic [19:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val
  task automatic chk_cnt(input string what, input int exp, input int got);
    checks++;
    if (got != exp) begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cnt
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr
  // answer is taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic wrc(input logic [3:0] a, input logic [7:0] d, input logic [7:0] m);
    wr(a, d);
    rd(a, rd_val);
    chk_val("readback", {12'h000, d & m}, {12'h000, rd_val});
  endtask : wrc
  // count high cycles of one pin over a window
  task automatic meas(input int p, input int ncyc, input int exp);
    int c;
    c = 0;
    repeat (ncyc) begin
      @(posedge clock_i);
      #1;
      if (level[p] === 1'b1) c++;
    end
    chk_cnt("high cycles", exp, c);
  endtask : meas
  // bounded wait for a rising edge on one pin
  task automatic wait_rise(input int p);
    logic prev;
    prev = 1'b1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clock_i);
      #1;
      if (prev === 1'b0 && level[p] === 1'b1) return;
      prev = level[p];
    end
    error_cnt++;
    $display("Error rise on pin %0d expected edge seen none", p);
    wrap_up();
  endtask : wait_rise

  initial begin
    nrst_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    osc_on_i = 1'b1;
    halt_i = 1'b0;
    cmp_i = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (3) @(posedge clock_i);
    chk_val("pins in reset", 20'h00000, {pin_o, pin_oe_o});
    nrst_i <= 1'b1;
    wr(4'he, 8'hff);
    for (n = 0; n < 16; n++) begin
      rd(n[3:0], rd_val);
      chk_val("reset value", 20'h00000, {12'h000, rd_val});
    end
    wrc(4'h6, 8'h04, 8'hff);
    wr(4'h7, 8'h40);
    wrc(4'h0, 8'h02, 8'hff);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h01);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h03);
    wr(4'h5, 8'h20);
    wr(4'h9, 8'h80);
    wr(4'ha, 8'h81);
    wrc(4'h8, 8'h9e, 8'hf1);
    // every ch2 pin choice, ending on PB3
    for (n = 0; n < 4; n++) begin
      wr(4'hb, 8'h80 | n[7:0]);
      repeat (3) @(posedge clock_i);
      chk_val("pin enables", 20'h00101 | (20'h1 << ch2_pin[n]), {10'h000, pin_oe_o});
    end
    wr(4'hb, 8'h82);
    repeat (80) @(posedge clock_i);
    wait_rise(0);
    chk_val("common start", 20'h3, {18'h0, level[8], level[5]});
    meas(0, 36, 17);
    meas(8, 36, 9);
    meas(5, 36, 26);
    // shrink ch0 early in a period: the running pulse keeps its length
    wait_rise(0);
    wr(4'h0, 8'h01);
    repeat (10) @(posedge clock_i);
    #1;
    chk_val("old duty held", 20'h1, {19'h0, level[0]});
    // the next duty write lands three whole periods after this one
    repeat (60) @(posedge clock_i);
    meas(0, 36, 9);
    wr(4'h0, 8'h02);
    // dead zones both high, then both low
    wr(4'h9, 8'he0);
    repeat (80) @(posedge clock_i);
    meas(0, 36, 28);
    wr(4'h9, 8'ha0);
    wr(4'hb, 8'hc2);
    repeat (80) @(posedge clock_i);
    meas(0, 36, 8);
    meas(5, 36, 10);
    wr(4'h9, 8'h90);
    wr(4'hb, 8'h82);
    repeat (80) @(posedge clock_i);
    meas(0, 36, 17);
    // prescale settings 1 to 7 against ch1
    for (n = 1; n < 8; n++) begin
      wr(4'h8, 8'h80 | (n[7:0] << 4));
      repeat (36 << n) @(posedge clock_i);
      meas(8, 18 << n, 9 << (n - 1));
    end
    wr(4'h8, 8'h81);
    repeat (300) @(posedge clock_i);
    meas(8, 144, 36);
    @(posedge clock_i);
    halt_i <= 1'b1;
    meas(8, 144, 36);
    @(posedge clock_i);
    osc_on_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    #1;
    meas(8, 60, (level[8] === 1'b1) ? 60 : 0);
    @(posedge clock_i);
    halt_i <= 1'b0;
    osc_on_i <= 1'b1;
    wr(4'h8, 8'h90);
    cmp_i <= 1'b1;
    repeat (40) @(posedge clock_i);
    meas(8, 36, 0);
    @(posedge clock_i);
    cmp_i <= 1'b0;
    repeat (80) @(posedge clock_i);
    meas(8, 36, 9);
    wrap_up();
  end
endmodule : triple_pwm_11bit_shared_base_tb_top
